// file: design/acs_cmd_mem.sv
// Purpose: command memory, one write port and one registered read port
// Assumes: write and read addresses below DEPTH
// Notes:   read data appear the edge after re
`timescale 1ns/1ps
module acs_cmd_mem #(
  parameter int DW    = 32,
  parameter int DEPTH = 1536,
  parameter int AW    = 11
) (
  input  wire logic          ref_clk,
  input  wire logic          en,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic          re,
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata
);
  logic [DW-1:0] mem [DEPTH];

  // no reset on the array so it maps onto block ram
  always_ff @(posedge ref_clk) begin
    if (en && we) begin
      mem[waddr] <= wdata;
    end
    if (en && re) begin
      rdata <= mem[raddr];
    end
  end
endmodule : acs_cmd_mem

// file: design/acs_down_counter.sv
// Purpose: loadable down counter used for delays and the timeout
// Assumes: clear has priority over load
// Notes:   expired is a one-cycle pulse on the step from 1 to 0
`timescale 1ns/1ps
module acs_down_counter #(
  parameter int W = 30
) (
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  input  wire logic         en,
  input  wire logic         clear,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  output logic      [W-1:0] count,
  output logic              running,
  output logic              expired
);
  assign running = (count != '0);
  assign expired = en && !clear && !load && (count == W'(1));

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
    end else if (en) begin
      if (clear) count <= '0;
      else if (load) count <= load_val;
      else if (running) count <= count - W'(1);
    end
  end
endmodule : acs_down_counter

// file: design/acs_pkg.sv
// Purpose: shared constants and types of the command sequencer
// Assumes: 32-bit APB register words, one clock domain
// Notes:   register offsets are byte addresses
package acs_pkg;
  localparam int APB_AW  = 8;
  localparam int APB_DW  = 32;
  localparam int MEM_AW  = 11;
  localparam int TMR_W   = 30;
  localparam int NUM_SEQ = 4;
  localparam int EV_W    = 3;

  localparam logic [APB_AW-1:0] OFS_CTRL     = 8'h00;
  localparam logic [APB_AW-1:0] OFS_COUNT    = 8'h04;
  localparam logic [APB_AW-1:0] OFS_CRC      = 8'h08;
  localparam logic [APB_AW-1:0] OFS_TRIG     = 8'h0C;
  localparam logic [APB_AW-1:0] OFS_ORDER    = 8'h10;
  localparam logic [APB_AW-1:0] OFS_STATUS   = 8'h14;
  localparam logic [APB_AW-1:0] OFS_MASK     = 8'h18;
  localparam logic [APB_AW-1:0] OFS_TMO      = 8'h1C;
  localparam logic [APB_AW-1:0] OFS_INFO0    = 8'h20;
  localparam logic [APB_AW-1:0] OFS_CMD_ADDR = 8'h30;
  localparam logic [APB_AW-1:0] OFS_CMD_DATA = 8'h34;

  localparam int CTRL_RUN_BIT   = 0;
  localparam int CTRL_PAUSE_BIT = 1;
  localparam int CTRL_DLY_LSB   = 8;
  localparam int TRIG_BIT       = 0;
  localparam int ORDER_NSEQ_LSB = 8;
  localparam int INFO_CNT_LSB   = 16;
  localparam logic [26:0] INFO_MASK = 27'h7FF07FF;

  localparam int CMD_WRITE_BIT = 31;
  localparam int CMD_TMO_BIT   = 30;
  localparam int CMD_ADDR_LSB  = 24;
  localparam int FE_AW         = 7;
  localparam int FE_DW         = 24;

  localparam logic [7:0] CRC_SEED = 8'h01;
  localparam logic [7:0] CRC_POLY = 8'h07;

  localparam int EV_END     = 0;
  localparam int EV_TMO_FIN = 1;
  localparam int EV_TMO_ERR = 2;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_LOAD  = 3'h1,
    ST_FETCH = 3'h3,
    ST_EXEC  = 3'h2,
    ST_DELAY = 3'h6,
    ST_NEXT  = 3'h7
  } acs_state_e;

  typedef struct packed {
    logic [FE_AW-1:0] addr;
    logic [FE_DW-1:0] data;
  } acs_fe_wr_s;
endpackage : acs_pkg

// file: design/acs_sequencer.sv
// Purpose: command sequencer, fetches and runs stored command sequences
// Assumes: APB slave with zero wait states while ce is high
// Notes:   front-end writes leave on afe_wr_valid / afe_wr
//
// How it works
// - four sequence descriptors kept in registers
// - triggers ignored while a sequence runs
// - write or delay, strictly in order
// - no read path, only front-end writes
// - run enable starts, zero disables
// - post-write delay after each write command
// - no post-write delay after timer commands
// - writes run back to back
// - pause freezes fetch, timers and outputs
// - register reads still served while paused
// - executed count adds one per command
// - count write clears count and checksum
// - CRC-8 with polynomial 0x07 over commands
// - one command word folded per cycle
// - checksum seed is 0x01
// - checksum register is read only
// - wake-up, serial and pin toggle triggers
// - host picks sequences and their order
// - write, wait and timeout command classes
// - events masked one by one
// - top bit one means write command
// - 7-bit address, 24-bit data field
// - wait resumes when its counter hits zero
// - timeout runs alone, finish and error events
//
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module acs_sequencer
  import acs_pkg::*;
#(
  parameter int MEM_DEPTH = 1536,
  parameter int DLY_W     = 8,
  parameter int CNT_W     = 16
) (
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              ce,
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [APB_DW-1:0] pwdata,
  output logic                   pready,
  output logic      [APB_DW-1:0] prdata,
  output logic                   pslverr,
  input  wire logic              wakeup_trigger,
  input  wire logic              gpio_trigger_pin,
  output logic                   afe_wr_valid,
  output acs_fe_wr_s             afe_wr,
  output logic                   sequencer_paused,
  output logic                   sequencer_busy,
  output logic      [EV_W-1:0]   seq_event
);
  acs_state_e              state;
  logic                    sequencer_run_enable;
  logic                    sequencer_pause;
  logic [DLY_W-1:0]        post_write_delay_count;
  logic [7:0]              seq_order;
  logic [1:0]              seq_last;
  logic [EV_W-1:0]         event_mask;
  logic [26:0]             seq_info [NUM_SEQ];
  logic [MEM_AW-1:0]       cmd_waddr;
  logic [CNT_W-1:0]        executed_command_count;
  logic [7:0]              command_checksum;
  logic [MEM_AW-1:0]       pc;
  logic [MEM_AW-1:0]       remaining;
  logic [1:0]              slot;
  logic [1:0]              cur_seq;
  logic                    sw_trigger;
  logic [2:0]              pin_sync;
  logic                    pin_stable;
  logic [APB_DW-1:0]       cmd_word;
  logic [TMR_W-1:0]        tmo_count;
  logic                    tmo_running;

  // ---------------- APB decode ----------------
  wire logic go        = ce && !sequencer_pause;
  wire logic apb_setup = ce && psel && !penable;
  wire logic wr_acc    = ce && psel && penable && pwrite;
  wire logic hit_ctrl  = (paddr == OFS_CTRL);
  wire logic hit_count = (paddr == OFS_COUNT);
  wire logic hit_trig  = (paddr == OFS_TRIG);
  wire logic hit_order = (paddr == OFS_ORDER);
  wire logic hit_mask  = (paddr == OFS_MASK);
  wire logic hit_info  = (paddr[7:4] == OFS_INFO0[7:4]) && (paddr[1:0] == 2'h0);
  wire logic hit_caddr = (paddr == OFS_CMD_ADDR);
  wire logic hit_cdata = (paddr == OFS_CMD_DATA);
  wire logic [1:0] info_idx = paddr[3:2];
  wire logic cnt_clear = wr_acc && hit_count;
  wire logic mem_we    = wr_acc && hit_cdata;

  logic [APB_DW-1:0] rd_mux;
  logic              rd_miss;

  // reads never depend on pause
  always_comb begin
    rd_mux  = '0;
    rd_miss = 1'b0;
    if (paddr == OFS_CTRL) begin
      rd_mux[CTRL_RUN_BIT]   = sequencer_run_enable;
      rd_mux[CTRL_PAUSE_BIT] = sequencer_pause;
      rd_mux[CTRL_DLY_LSB +: DLY_W] = post_write_delay_count;
    end else if (paddr == OFS_COUNT) begin
      rd_mux[CNT_W-1:0] = executed_command_count;
    end else if (paddr == OFS_CRC) begin
      rd_mux[7:0] = command_checksum;
    end else if (paddr == OFS_TRIG) begin
      rd_mux = '0;
    end else if (paddr == OFS_ORDER) begin
      rd_mux[7:0] = seq_order;
      rd_mux[ORDER_NSEQ_LSB +: 2] = seq_last;
    end else if (paddr == OFS_STATUS) begin
      rd_mux[0]   = (state != ST_IDLE);
      rd_mux[2:1] = cur_seq;
      rd_mux[3]   = tmo_running;
      rd_mux[4]   = sequencer_pause;
    end else if (paddr == OFS_MASK) begin
      rd_mux[EV_W-1:0] = event_mask;
    end else if (paddr == OFS_TMO) begin
      rd_mux[TMR_W-1:0] = tmo_count;
    end else if (hit_info) begin
      rd_mux[26:0] = seq_info[info_idx];
    end else if (paddr == OFS_CMD_ADDR) begin
      rd_mux[MEM_AW-1:0] = cmd_waddr;
    end else if (paddr == OFS_CMD_DATA) begin
      rd_mux = '0;
    end else begin
      rd_miss = 1'b1;
    end
  end

  assign pready = ce;

  // read data and error latched in setup, stable through access
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end else if (apb_setup) begin
      prdata  <= pwrite ? '0 : rd_mux;
      pslverr <= rd_miss;
    end
  end

  // ---------------- control registers ----------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sequencer_run_enable   <= 1'b0;
      sequencer_pause        <= 1'b0;
      post_write_delay_count <= '0;
      seq_order              <= 8'hE4;
      seq_last               <= 2'h0;
      event_mask             <= '0;
      sw_trigger             <= 1'b0;
    end else if (ce) begin
      sw_trigger <= wr_acc && hit_trig && pwdata[TRIG_BIT];
      if (wr_acc && hit_ctrl) begin
        sequencer_run_enable   <= pwdata[CTRL_RUN_BIT];
        sequencer_pause        <= pwdata[CTRL_PAUSE_BIT];
        post_write_delay_count <= pwdata[CTRL_DLY_LSB +: DLY_W];
      end
      if (wr_acc && hit_order) begin
        seq_order <= pwdata[7:0];
        seq_last  <= pwdata[ORDER_NSEQ_LSB +: 2];
      end
      if (wr_acc && hit_mask) event_mask <= pwdata[EV_W-1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_SEQ; i++) seq_info[i] <= '0;
      cmd_waddr <= '0;
    end else if (ce) begin
      if (wr_acc && hit_info) seq_info[info_idx] <= pwdata[26:0] & INFO_MASK;
      if (wr_acc && hit_caddr) cmd_waddr <= pwdata[MEM_AW-1:0];
      else if (mem_we) cmd_waddr <= cmd_waddr + MEM_AW'(1);
    end
  end

  // ---------------- trigger sources ----------------
  // pin comes from outside, three flops and agreement of the last two
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_sync   <= 3'h0;
      pin_stable <= 1'b0;
    end else if (ce) begin
      pin_sync <= {pin_sync[1:0], gpio_trigger_pin};
      if (pin_sync[1] == pin_sync[2]) pin_stable <= pin_sync[2];
    end
  end

  wire logic pin_toggle = (pin_sync[1] == pin_sync[2]) && (pin_sync[2] != pin_stable);
  wire logic trigger    = wakeup_trigger || sw_trigger || pin_toggle;
  // a trigger while busy or paused is dropped, not queued
  wire logic start      = go && sequencer_run_enable && (state == ST_IDLE) && trigger;

  // ---------------- command memory and timers ----------------
  wire logic fetch_re = go && (state == ST_FETCH);
  wire logic in_exec  = go && sequencer_run_enable && (state == ST_EXEC);
  wire logic is_write = cmd_word[CMD_WRITE_BIT];
  wire logic is_tmo   = !is_write && cmd_word[CMD_TMO_BIT];
  wire logic is_wait  = !is_write && !cmd_word[CMD_TMO_BIT];
  wire logic [TMR_W-1:0] cmd_time = cmd_word[TMR_W-1:0];
  wire logic [TMR_W-1:0] post_dly = TMR_W'(post_write_delay_count);

  logic [TMR_W-1:0] wait_count;
  logic             wait_running;
  logic             tmo_expired;

  acs_cmd_mem #(
    .DW    (APB_DW),
    .DEPTH (MEM_DEPTH),
    .AW    (MEM_AW)
  ) u_mem (
    .ref_clk (ref_clk),
    .en      (ce),
    .we      (mem_we),
    .waddr   (cmd_waddr),
    .wdata   (pwdata),
    .re      (fetch_re),
    .raddr   (pc),
    .rdata   (cmd_word)
  );

  // one counter serves wait commands and the post-write delay
  acs_down_counter #(.W(TMR_W)) u_wait (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .en       (go),
    .clear    (!sequencer_run_enable),
    .load     (in_exec && !is_tmo),
    .load_val (is_write ? post_dly : cmd_time),
    .count    (wait_count),
    .running  (wait_running),
    .expired  ()
  );

  acs_down_counter #(.W(TMR_W)) u_tmo (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .en       (go),
    .clear    (!sequencer_run_enable),
    .load     (in_exec && is_tmo),
    .load_val (cmd_time),
    .count    (tmo_count),
    .running  (tmo_running),
    .expired  (tmo_expired)
  );

  // ---------------- checksum ----------------
  function automatic logic [7:0] crc8_fold(input logic [7:0] c, input logic [31:0] d);
    logic [7:0] r;
    logic       fb;
    r = c;
    for (int i = 31; i >= 0; i--) begin
      fb = r[7] ^ d[i];
      r  = {r[6:0], 1'b0};
      if (fb) r = r ^ CRC_POLY;
    end
    return r;
  endfunction : crc8_fold

  // clear then fold, so a command run in the clearing cycle still counts
  wire logic [CNT_W-1:0] cnt_base = cnt_clear ? '0 : executed_command_count;
  wire logic [7:0]       crc_base = cnt_clear ? CRC_SEED : command_checksum;
  wire logic [CNT_W-1:0] next_count = in_exec ? cnt_base + CNT_W'(1) : cnt_base;
  wire logic [7:0]       next_crc = in_exec ? crc8_fold(crc_base, cmd_word) : crc_base;

  // no write path to the checksum exists
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      executed_command_count <= '0;
      command_checksum       <= CRC_SEED;
    end else if (ce) begin
      executed_command_count <= next_count;
      command_checksum       <= next_crc;
    end
  end

  // ---------------- fetch and execute ----------------
  wire logic [1:0]  sel_seq   = seq_order[2*slot +: 2];
  wire logic [26:0] sel_info  = seq_info[sel_seq];
  wire logic [MEM_AW-1:0] sel_cnt = sel_info[INFO_CNT_LSB +: MEM_AW];
  wire logic last_cmd = (remaining == MEM_AW'(1));
  wire logic seq_done = go && (state == ST_NEXT) && last_cmd && (slot == seq_last);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state     <= ST_IDLE;
      pc        <= '0;
      remaining <= '0;
      slot      <= 2'h0;
      cur_seq   <= 2'h0;
    end else if (ce && !sequencer_run_enable) begin
      state <= ST_IDLE;
    end else if (go) begin
      case (state)
        ST_IDLE: begin
          if (start) begin
            slot  <= 2'h0;
            state <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          cur_seq   <= sel_seq;
          pc        <= sel_info[MEM_AW-1:0];
          remaining <= (sel_cnt == '0) ? MEM_AW'(1) : sel_cnt;
          state     <= (sel_cnt == '0) ? ST_NEXT : ST_FETCH;
        end
        ST_FETCH: begin
          state <= ST_EXEC;
        end
        ST_EXEC: begin
          // timeouts never delay, writes only when a delay is set
          if (is_tmo) state <= ST_NEXT;
          else if (is_write) state <= (post_dly == '0) ? ST_NEXT : ST_DELAY;
          else state <= (cmd_time == '0) ? ST_NEXT : ST_DELAY;
        end
        ST_DELAY: begin
          if (!wait_running) state <= ST_NEXT;
        end
        ST_NEXT: begin
          pc        <= pc + MEM_AW'(1);
          remaining <= remaining - MEM_AW'(1);
          if (!last_cmd) begin
            state <= ST_FETCH;
          end else if (slot == seq_last) begin
            state <= ST_IDLE;
          end else begin
            slot  <= slot + 2'h1;
            state <= ST_LOAD;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ---------------- outputs ----------------
  wire logic [EV_W-1:0] ev_raw = {tmo_expired && (state != ST_IDLE), tmo_expired, seq_done};

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      afe_wr_valid <= 1'b0;
      afe_wr       <= '0;
      seq_event    <= '0;
    end else if (ce) begin
      afe_wr_valid <= in_exec && is_write;
      if (in_exec && is_write) begin
        afe_wr.addr <= cmd_word[CMD_ADDR_LSB +: FE_AW];
        afe_wr.data <= cmd_word[FE_DW-1:0];
      end
      seq_event <= ev_raw & event_mask;
    end
  end

  assign sequencer_paused = sequencer_pause;
  assign sequencer_busy   = (state != ST_IDLE);
endmodule : acs_sequencer

// file: tb/acs_fe_model.sv
// Purpose: front-end register block that takes the sequencer's writes
// Assumes: one write per valid pulse, taken at the rising edge
// Notes:   write-only from the sequencer side, the bench peeks into regs
`timescale 1ns/1ps
module acs_fe_model
  import acs_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       wr_valid,
  input  wire acs_fe_wr_s wr
);
  logic [FE_DW-1:0] regs [2**FE_AW];

  // word index is the whole 7-bit address, bits 6 down to 0; no read port exists
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 2**FE_AW; i++) regs[i] <= '0;
    end else if (wr_valid) begin
      regs[wr.addr] <= wr.data;
    end
  end
endmodule : acs_fe_model

// file: tb/acs_sequencer_sva.sv
// Purpose: port-level checks of the command sequencer
// Assumes: single clock, reset active low
// Notes:   bound to every acs_sequencer instance
`timescale 1ns/1ps
module acs_sequencer_chk
  import acs_pkg::*;
(
  input wire logic              ref_clk,
  input wire logic              rst_n,
  input wire logic              ce,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pready,
  input wire logic [APB_DW-1:0] prdata,
  input wire logic              pslverr,
  input wire logic              afe_wr_valid,
  input wire acs_fe_wr_s        afe_wr,
  input wire logic              sequencer_paused,
  input wire logic              sequencer_busy,
  input wire logic [EV_W-1:0]   seq_event
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  property p_read_paused; sequencer_paused && psel |-> pready == ce; endproperty
  property p_wr_gap; afe_wr_valid |=> !afe_wr_valid [*2]; endproperty
  property p_pause_quiet; sequencer_paused [*3] |-> !afe_wr_valid; endproperty
  property p_busy_wr; afe_wr_valid |-> sequencer_busy; endproperty
  property p_wr_hold; !afe_wr_valid |-> $stable(afe_wr); endproperty
  property p_unmapped;
    psel && penable && paddr > OFS_CMD_DATA |-> pslverr && prdata == '0;
  endproperty
  property p_end_ev; seq_event[EV_END] |-> !sequencer_busy && $past(sequencer_busy); endproperty
  property p_tmo_err; seq_event[EV_TMO_ERR] |-> $past(sequencer_busy); endproperty
  property p_tmo_pulse; seq_event[EV_TMO_FIN] |=> !seq_event[EV_TMO_FIN]; endproperty

  a_read_paused: assert property (p_read_paused) else $error("no answer while paused");
  a_wr_gap: assert property (p_wr_gap) else $error("writes too close");
  a_pause_quiet: assert property (p_pause_quiet) else $error("write while paused");
  a_busy_wr: assert property (p_busy_wr) else $error("write while idle");
  a_wr_hold: assert property (p_wr_hold) else $error("write bus moved");
  a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
  a_end_ev: assert property (p_end_ev) else $error("end event off idle");
  a_tmo_err: assert property (p_tmo_err) else $error("error event when idle");
  a_tmo_pulse: assert property (p_tmo_pulse) else $error("finish event too long");

  c_back_to_back: cover property (afe_wr_valid ##3 afe_wr_valid);
  c_tmo_err: cover property (seq_event[EV_TMO_ERR]);
  c_paused: cover property (sequencer_paused [*3]);
endmodule : acs_sequencer_chk

bind acs_sequencer acs_sequencer_chk acs_sequencer_chk_i (
  .ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .paddr(paddr), .psel(psel),
  .penable(penable), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .afe_wr_valid(afe_wr_valid), .afe_wr(afe_wr), .sequencer_paused(sequencer_paused),
  .sequencer_busy(sequencer_busy), .seq_event(seq_event));

// file: tb/afe_command_sequencer_tb.sv
// Purpose: self-checking bench of the command sequencer
// Assumes: clock enable held high, APB master in this bench
// Notes:   expected front-end writes queued at trigger, checked by monitor
`timescale 1ns/1ps
module afe_command_sequencer_tb
  import acs_pkg::*;
;
  logic              ref_clk, rst_n, ce, psel, penable, pwrite, pready, pslverr;
  logic              wakeup_trigger, gpio_trigger_pin, afe_wr_valid;
  logic              sequencer_paused, sequencer_busy, err;
  logic [APB_AW-1:0] paddr;
  logic [APB_DW-1:0] pwdata, prdata, rd, c1, rng;
  acs_fe_wr_s        afe_wr;
  logic [EV_W-1:0]   seq_event, ev_seen;
  logic [30:0]       exp_q[$];
  int                gap_q[$];
  logic [31:0]       cmds[10];
  logic [7:0]        crc;
  int                n_fail, check_count, t, last_t;

  acs_sequencer acs_sequencer_i (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .wakeup_trigger(wakeup_trigger),
    .gpio_trigger_pin(gpio_trigger_pin), .afe_wr_valid(afe_wr_valid), .afe_wr(afe_wr),
    .sequencer_paused(sequencer_paused), .sequencer_busy(sequencer_busy),
    .seq_event(seq_event));
  acs_fe_model acs_fe_model_i (.ref_clk(ref_clk), .rst_n(rst_n), .wr_valid(afe_wr_valid),
    .wr(afe_wr));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  // msb first, no reflection or final inversion
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [31:0] w);
    for (int i = 31; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? CRC_POLY : 8'h00);
    return c;
  endfunction : crc8

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish

  // first edge keeps a released strobe from being raised in the same step
  task automatic apb(input logic wr, input logic [APB_AW-1:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // no cap here, the watchdog ends a hung wait
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // synchroniser plus load stage before busy can show
  task automatic wait_idle;
    int n;
    n = 0;
    repeat (8) @(negedge ref_clk);
    while (sequencer_busy !== 1'b0 && n < 3000) begin
      @(negedge ref_clk);
      n++;
    end
    @(negedge ref_clk);
    chk("idle wait", {31'b0, n >= 3000}, 0);
  endtask : wait_idle

  task automatic exp_seq(input int s, input int n);
    for (int k = s; k < s + n; k++) begin
      if (cmds[k][31]) exp_q.push_back(cmds[k][30:0]);
      crc = crc8(crc, cmds[k]);
    end
  endtask : exp_seq

  always @(negedge ref_clk) begin
    t++;
    if (rst_n) ev_seen |= seq_event;
    if (afe_wr_valid === 1'b1) begin
      gap_q.push_back(t - last_t);
      last_t = t;
      if (exp_q.size() == 0) chk("surplus afe_wr", 1, 0);
      else chk("afe_wr", {1'b0, afe_wr}, {1'b0, exp_q.pop_front()});
    end
  end

  initial begin
    #1ms;
    n_fail++;
    tally_and_finish();
  end

  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    wakeup_trigger = 1'b0;
    gpio_trigger_pin = 1'b0;
    ev_seen = '0;
    rng = 32'h45;
    crc = 8'h01;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    apb(0, OFS_CRC, 0);
    chk("crc reset", rd, 32'h01);
    for (int k = 0; k < 10; k++) begin
      rng = xs(rng);
      cmds[k] = {1'b1, rng[30:0]};
    end
    cmds[3] = 32'h0000_0005;
    cmds[5] = 32'h4000_000C;
    cmds[6] = 32'h0000_0028;
    cmds[8] = 32'h4000_012C;
    cmds[9] = 32'h0000_012C;
    apb(1, OFS_CMD_ADDR, 0);
    for (int k = 0; k < 10; k++) apb(1, OFS_CMD_DATA, cmds[k]);
    apb(1, OFS_INFO0, 32'h0004_0000);
    apb(1, OFS_INFO0 + 8'h04, 32'h0003_0004);
    apb(1, OFS_INFO0 + 8'h08, 32'h0003_0007);
    apb(1, OFS_MASK, 32'h7);
    apb(1, OFS_CTRL, 32'h0000_0401);
    exp_seq(0, 4);
    gap_q.delete();
    apb(1, OFS_TRIG, 1);
    wait_idle();
    chk("delayed gap", gap_q[2], 8);
    apb(0, OFS_COUNT, 0);
    chk("count", rd, 4);
    apb(0, OFS_CRC, 0);
    chk("crc", rd, {24'h0, crc});
    apb(1, OFS_CRC, 32'hFF);
    apb(0, OFS_CRC, 0);
    chk("crc read only", rd, {24'h0, crc});
    apb(1, OFS_COUNT, 32'h5A);
    apb(0, OFS_COUNT, 0);
    chk("count clear", rd, 0);
    apb(0, OFS_CRC, 0);
    chk("crc clear", rd, 32'h01);
    apb(0, 8'h40, 0);
    chk("unmapped", {31'b0, err}, 1);
    apb(1, OFS_CTRL, 1);
    apb(1, OFS_ORDER, 32'h101);
    exp_seq(4, 3);
    exp_seq(0, 4);
    gap_q.delete();
    ev_seen = '0;
    wakeup_trigger <= 1'b1;
    @(posedge ref_clk);
    wakeup_trigger <= 1'b0;
    wait_idle();
    chk("back to back gap", gap_q[2], 3);
    chk("events", ev_seen, 3'h7);
    apb(1, OFS_MASK, 0);
    exp_seq(4, 3);
    exp_seq(0, 4);
    ev_seen = '0;
    gpio_trigger_pin <= 1'b1;
    wait_idle();
    chk("masked events", ev_seen, 0);
    apb(1, OFS_MASK, 32'h7);
    apb(1, OFS_ORDER, 32'h002);
    exp_seq(7, 3);
    apb(1, OFS_TRIG, 1);
    repeat (10) @(negedge ref_clk);
    apb(1, OFS_CTRL, 32'h3);
    apb(0, OFS_TMO, 0);
    c1 = rd;
    chk("timer running", {31'b0, c1 != 0}, 1);
    repeat (20) @(negedge ref_clk);
    apb(0, OFS_TMO, 0);
    chk("timer frozen", rd, c1);
    chk("paused flag", {31'b0, sequencer_paused}, 1);
    apb(1, OFS_CTRL, 1);
    apb(1, OFS_CTRL, 0);
    repeat (2) @(negedge ref_clk);
    chk("busy after disable", {31'b0, sequencer_busy}, 0);
    apb(0, OFS_TMO, 0);
    chk("timeout cleared", rd, 0);
    chk("pending writes", exp_q.size(), 0);
    chk("fe reg", {8'h0, acs_fe_model_i.regs[cmds[7][30:24]]}, {8'h0, cmds[7][23:0]});
    tally_and_finish();
  end
endmodule : afe_command_sequencer_tb
